/* src/lookup_engine.sv */
// lookup engine: migration, aging and two-stage forwarding
// assumes receive logic and table lookups on the switch clock
//
// Operation
// - known dynamic source on a new port gets its stored port rewritten
// - migration only for error-free frames of legal length
// - source hit on a dynamic entry clears its age
// - aging runs in background and removes stale dynamic entries
// - aging period defaults to 300 s, settable from 1 s to 30 min
// - a control bit turns aging on or off
// - static entries are never aged out
// - first stage port set from vlan, static and dynamic lookups
// - stage one set trimmed by spanning tree and masks, replaced by snooping, extended by mirroring
// - access-control result has top priority and may override
// - access-control output is the final egress port set; the code still ANDs it with the egress mask and removes the arrival port
// - frames with framing, checksum, alignment or size errors dropped
// - pause frames consumed and turned into flow-control requests
// - lookup resolving to the arrival port marks frame local, dropped
// - in-band management frames go to no switch port
// - per-ingress egress mask excludes ports from forwarding
// - egress mask applies regardless of tag vlan mode
// - egress masks allow all ports after reset
// - static table match wins over dynamic match
//
// Implementation choices: the address map and the Wishbone interface to the registers.
module lookup_engine
  import lookup_pkg::*;
#(
  parameter int CYCLES_PER_SEC = TICK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // frame request and table results
  input wire logic i_frm_valid,
  input wire frm_req_t i_frm,
  input wire tbl_res_t i_tbl,
  // forwarding result
  output logic o_fwd_valid,
  output fwd_res_t o_fwd,
  // flow control
  output logic o_pause_valid,
  output pause_t o_pause
);
  // ****************************************
  // declarations
  // ****************************************
  logic [TABLE_DEPTH-1:0] ent_valid_reg, ent_static_reg;
  logic [MAC_W-1:0] ent_mac_reg [TABLE_DEPTH];
  logic [PORT_W-1:0] ent_port_reg [TABLE_DEPTH];
  logic [AGE_W-1:0] ent_age_reg [TABLE_DEPTH];
  port_set_t egr_mask_reg [NUM_PORTS];
  logic [31:0] ctrl_reg, ent_lo_reg, ent_hi_reg, ent_ctrl_reg;
  logic [31:0] ent_ctrl_next, rd_data;
  logic [AGE_W-1:0] age_period_reg;
  wb_state_t wb_state_reg;
  logic tick, wb_take, wb_wr, ent_wr, good, sa_learnable;
  logic sa_hit, da_hit, is_local, drop;
  logic [IDX_W-1:0] sa_idx, da_idx;
  port_set_t in_set, stage_set, fin_set, src_set;
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return r;
  endfunction
  function automatic port_set_t onehot(input logic [PORT_W-1:0] p);
    return port_set_t'(1) << p;
  endfunction
  function automatic logic [AGE_W-1:0] clamp_age(input logic [31:0] v);
    if (v < 32'(AGE_MIN_S)) begin
      return AGE_MIN_S;
    end else if (v > 32'(AGE_MAX_S)) begin
      return AGE_MAX_S;
    end
    return v[AGE_W-1:0];
  endfunction
  // ****************************************
  // aging tick
  // ****************************************
  age_ticker #(
    .CYCLES(CYCLES_PER_SEC)
  ) u_ticker (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .o_tick(tick)
  );
  // ****************************************
  // table search
  // ****************************************
  always_comb begin
    sa_hit = 1'b0;
    sa_idx = '0;
    da_hit = 1'b0;
    da_idx = '0;
    for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
      if (ent_valid_reg[i] && ent_mac_reg[i] == i_frm.sa) begin
        sa_hit = 1'b1;
        sa_idx = IDX_W'(i);
      end
      if (ent_valid_reg[i] && ent_mac_reg[i] == i_frm.da) begin
        da_hit = 1'b1;
        da_idx = IDX_W'(i);
      end
    end
  end
  assign good = ~|i_frm.err & i_frm.size_ok;
  assign sa_learnable = i_frm_valid & good & sa_hit
                        & ~ent_static_reg[sa_idx];
  // ****************************************
  // forwarding decision
  // ****************************************
  always_comb begin
    src_set = onehot(i_frm.port);
    if (i_tbl.static_hit) begin
      in_set = i_tbl.static_ports;
    end else if (da_hit) begin
      in_set = onehot(ent_port_reg[da_idx]);
    end else begin
      in_set = i_tbl.vlan_ports;
    end
    is_local = (i_tbl.static_hit | da_hit) & (in_set == src_set);
    stage_set = in_set & i_tbl.stp_ports;
    if (i_tbl.igmp_hit) begin
      stage_set = i_tbl.igmp_ports & i_tbl.stp_ports;
    end
    stage_set = stage_set | i_tbl.mirror_ports;
    stage_set = stage_set & egr_mask_reg[i_frm.port];
    fin_set = i_tbl.acl_hit ? i_tbl.acl_ports : stage_set;
    fin_set = fin_set & egr_mask_reg[i_frm.port] & ~src_set;
    drop = ~good | i_frm.is_pause | i_frm.is_mgmt | is_local;
    if (drop) begin
      fin_set = '0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fwd_valid <= 1'b0;
      o_fwd <= '0;
    end else begin
      o_fwd_valid <= i_frm_valid;
      if (i_frm_valid) begin
        o_fwd.initial_dest_port_set <= in_set;
        o_fwd.final_dest_port_set <= fin_set;
        o_fwd.drop <= drop;
        o_fwd.is_local <= is_local;
      end
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pause_valid <= 1'b0;
      o_pause <= '0;
    end else begin
      o_pause_valid <= i_frm_valid & good & i_frm.is_pause;
      if (i_frm_valid & good & i_frm.is_pause) begin
        o_pause.port <= i_frm.port;
        o_pause.quanta <= i_frm.pause_quanta;
      end
    end
  end
  // ****************************************
  // address table
  // ****************************************
  assign ent_ctrl_next = merge(ent_ctrl_reg, i_wb_dat, i_wb_sel);
  assign ent_wr = wb_wr & (i_wb_adr == REG_ENT_CTRL);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ent_valid_reg <= '0;
      ent_static_reg <= '0;
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        ent_mac_reg[i] <= '0;
        ent_port_reg[i] <= '0;
        ent_age_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        if (ent_wr && ent_ctrl_next[ENT_IDX_LSB +: IDX_W] == IDX_W'(i)) begin
          ent_valid_reg[i] <= ent_ctrl_next[ENT_VALID_BIT];
          ent_static_reg[i] <= ent_ctrl_next[ENT_STATIC_BIT];
          ent_mac_reg[i] <= {ent_hi_reg[15:0], ent_lo_reg};
          ent_port_reg[i] <= ent_ctrl_next[ENT_PORT_LSB +: PORT_W];
          ent_age_reg[i] <= '0;
        end else if (sa_learnable && sa_idx == IDX_W'(i)) begin
          ent_age_reg[i] <= '0;
          ent_port_reg[i] <= i_frm.port;
        end else if (tick && ctrl_reg[CTRL_AGE_EN_BIT]
                     && ent_valid_reg[i] && !ent_static_reg[i]) begin
          if (ent_age_reg[i] >= age_period_reg - 1'b1) begin
            ent_valid_reg[i] <= 1'b0;
          end else begin
            ent_age_reg[i] <= ent_age_reg[i] + 1'b1;
          end
        end
      end
    end
  end
  // ****************************************
  // wishbone slave
  // ****************************************
  assign wb_take = i_wb_cyc & i_wb_stb & (wb_state_reg == WB_IDLE);
  // writes land on the edge where the master sees ack, request still held
  assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & (wb_state_reg == WB_ACK);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (i_wb_adr)
      REG_CTRL: rd_data = ctrl_reg;
      REG_AGE_PERIOD: rd_data = 32'(age_period_reg);
      REG_STATUS: rd_data = 32'($countones(ent_valid_reg));
      REG_ENT_MAC_LO: rd_data = ent_lo_reg;
      REG_ENT_MAC_HI: rd_data = ent_hi_reg;
      REG_ENT_CTRL: rd_data = ent_ctrl_reg;
      default: begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (i_wb_adr == REG_EGR_MASK_BASE + 8'(4 * p)) begin
            rd_data = 32'(egr_mask_reg[p]);
          end
        end
      end
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wb_state_reg <= WB_IDLE;
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      case (wb_state_reg)
        WB_IDLE: begin
          if (wb_take) begin
            o_wb_ack <= 1'b1;
            o_wb_dat <= i_wb_we ? 32'h0000_0000 : rd_data;
            wb_state_reg <= WB_ACK;
          end
        end
        WB_ACK: begin
          o_wb_ack <= 1'b0;
          wb_state_reg <= WB_IDLE;
        end
        default: begin
          o_wb_ack <= 1'b0;
          wb_state_reg <= WB_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= CTRL_RESET;
      age_period_reg <= AGE_DEFAULT_S;
      ent_lo_reg <= '0;
      ent_hi_reg <= '0;
      ent_ctrl_reg <= '0;
    end else if (wb_wr) begin
      case (i_wb_adr)
        REG_CTRL: ctrl_reg <= merge(ctrl_reg, i_wb_dat, i_wb_sel) & CTRL_RESET;
        REG_AGE_PERIOD: begin
          age_period_reg <= clamp_age(merge(32'(age_period_reg), i_wb_dat,
                                            i_wb_sel));
        end
        REG_ENT_MAC_LO: ent_lo_reg <= merge(ent_lo_reg, i_wb_dat, i_wb_sel);
        REG_ENT_MAC_HI: begin
          ent_hi_reg <= merge(ent_hi_reg, i_wb_dat, i_wb_sel) & 32'h0000_ffff;
        end
        REG_ENT_CTRL: ent_ctrl_reg <= ent_ctrl_next;
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        egr_mask_reg[p] <= EGR_MASK_RESET;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wb_wr && i_wb_adr == REG_EGR_MASK_BASE + 8'(4 * p)) begin
          egr_mask_reg[p] <= port_set_t'(merge(32'(egr_mask_reg[p]),
                                               i_wb_dat, i_wb_sel));
        end
      end
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_drop_errors: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid && (|i_frm.err || !i_frm.size_ok)
    |=> o_fwd_valid && o_fwd.drop && o_fwd.final_dest_port_set == '0)
    else $error("error frame forwarded");
  a_pause_consumed: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid && good && i_frm.is_pause
    |=> o_pause_valid && o_fwd.drop && o_pause.port == $past(i_frm.port))
    else $error("pause frame not consumed");
  a_local_drop: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid && is_local |=> o_fwd.final_dest_port_set == '0)
    else $error("local frame forwarded");
  a_mgmt_drop: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid && i_frm.is_mgmt |=> o_fwd.final_dest_port_set == '0)
    else $error("management frame forwarded");
  a_mask_respect: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid |=> (o_fwd.final_dest_port_set
                     & ~$past(egr_mask_reg[i_frm.port])) == '0)
    else $error("egress mask violated");
  a_acl_override: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid && i_tbl.acl_hit && !drop
    |=> o_fwd.final_dest_port_set == ($past(i_tbl.acl_ports)
        & $past(egr_mask_reg[i_frm.port]) & ~$past(src_set)))
    else $error("acl result not final");
  a_static_pref: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid && i_tbl.static_hit
    |=> o_fwd.initial_dest_port_set == $past(i_tbl.static_ports))
    else $error("static entry lost priority");
  a_static_kept: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    |($past(ent_valid_reg & ent_static_reg) & ~ent_valid_reg)
    |-> $past(ent_wr))
    else $error("static entry removed");
  a_aging_off: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !ctrl_reg[CTRL_AGE_EN_BIT] && !ent_wr
    |=> (~ent_valid_reg & $past(ent_valid_reg)) == '0)
    else $error("entry aged while aging off");
  a_migrate: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    sa_learnable && !ent_wr
    |=> ent_port_reg[$past(sa_idx)] == $past(i_frm.port)
        && ent_age_reg[$past(sa_idx)] == '0)
    else $error("migration or refresh missed");
  a_period_range: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    age_period_reg >= AGE_MIN_S && age_period_reg <= AGE_MAX_S)
    else $error("aging period out of range");

  c_migrate: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    sa_learnable && ent_port_reg[sa_idx] != i_frm.port);
  c_age_out: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    |($past(ent_valid_reg) & ~ent_valid_reg) && !$past(ent_wr));
  c_acl: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_frm_valid && i_tbl.acl_hit && !drop);
endmodule

/* src/lookup_pkg.sv */
// lookup engine constants, register map and carrier types
// assumes one 250 MHz switch clock shared by all users of the package
package lookup_pkg;
  // ****************************************
  // geometry
  // ****************************************
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 3;
  localparam int MAC_W = 48;
  localparam int TABLE_DEPTH = 16;
  localparam int IDX_W = 4;
  localparam int AGE_W = 11;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int TICK_TIME_S = 1;
  localparam int TICK_CYCLES = CLK_FREQ_HZ * TICK_TIME_S;
  localparam logic [AGE_W-1:0] AGE_DEFAULT_S = 11'h12c;
  localparam logic [AGE_W-1:0] AGE_MIN_S = 11'h001;
  localparam logic [AGE_W-1:0] AGE_MAX_S = 11'h708;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AGE_PERIOD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ENT_MAC_LO = 8'h10;
  localparam logic [7:0] REG_ENT_MAC_HI = 8'h14;
  localparam logic [7:0] REG_ENT_CTRL = 8'h18;
  localparam logic [7:0] REG_EGR_MASK_BASE = 8'h20;
  localparam int CTRL_AGE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int ENT_IDX_LSB = 0;
  localparam int ENT_PORT_LSB = 8;
  localparam int ENT_STATIC_BIT = 16;
  localparam int ENT_VALID_BIT = 17;
  localparam logic [NUM_PORTS-1:0] EGR_MASK_RESET = 7'h7f;
  // ****************************************
  // carrier types
  // ****************************************
  typedef logic [NUM_PORTS-1:0] port_set_t;
  typedef struct packed {
    logic [MAC_W-1:0] sa;
    logic [MAC_W-1:0] da;
    logic [PORT_W-1:0] port;
    logic [3:0] err;
    logic size_ok;
    logic is_pause;
    logic is_mgmt;
    logic [15:0] pause_quanta;
  } frm_req_t;
  typedef struct packed {
    logic static_hit;
    port_set_t static_ports;
    port_set_t vlan_ports;
    port_set_t stp_ports;
    logic igmp_hit;
    port_set_t igmp_ports;
    port_set_t mirror_ports;
    logic acl_hit;
    port_set_t acl_ports;
  } tbl_res_t;
  typedef struct packed {
    port_set_t initial_dest_port_set;
    port_set_t final_dest_port_set;
    logic drop;
    logic is_local;
  } fwd_res_t;
  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [15:0] quanta;
  } pause_t;
  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } wb_state_t;
endpackage

/* src/age_ticker.sv */
// one-second enable pulse for the aging sweep
// assumes the switch clock runs free from reset
module age_ticker
  import lookup_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // tick out
  output logic o_tick
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;

  // ****************************************
  // divider
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_reg == CNT_LAST);
      if (cnt_reg == CNT_LAST) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  a_tick_spacing: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_tick |-> cnt_reg == '0 && $past(cnt_reg) == CNT_LAST)
    else $error("tick not at end of second");
endmodule

/* testbench/rx_source.sv */
// receive-side model: presents one frame request with its table results
// assumes the switch clock of the lookup engine; no back-pressure exists
module rx_source
  import lookup_pkg::*;
(
  // clock
  input wire logic i_mclk,
  // frame request and table results
  output logic o_frm_valid,
  output frm_req_t o_frm,
  output tbl_res_t o_tbl
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_frm_valid = 1'b0;
    o_frm = '0;
    o_tbl = '0;
  end

  // **************************************
  // one request, then the lines turn stale
  // **************************************
  task automatic send(input frm_req_t fr, input tbl_res_t tr);
    @(posedge i_mclk);
    o_frm_valid <= 1'b1;
    o_frm <= fr;
    o_tbl <= tr;
    @(posedge i_mclk);
    o_frm_valid <= 1'b0;
    // stale lines carry the inverse so no old value looks current
    o_frm <= ~fr;
    o_tbl <= ~tr;
  endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the lookup engine
// assumes a 250 MHz clock and a one-second tick shortened to 8 cycles
module testbench
  import lookup_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, o_fwd_valid, o_pause_valid, frm_valid, is_rd;
  fwd_res_t o_fwd;
  pause_t o_pause;
  frm_req_t frm, f;
  tbl_res_t tbl, t;
  port_set_t mask [NUM_PORTS];
  logic [31:0] exp_rd [$];
  fwd_res_t exp_fwd [$];
  pause_t exp_pause [$];
  int n_fail = 0;
  int checks = 0;
  logic [47:0] mac_a, mac_b;

  always #2 clk = ~clk;

  rx_source src (.i_mclk(clk), .o_frm_valid(frm_valid), .o_frm(frm),
    .o_tbl(tbl));

  lookup_engine #(.CYCLES_PER_SEC(8)) dut (.i_mclk(clk), .i_rst_b(rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_frm_valid(frm_valid), .i_frm(frm),
    .i_tbl(tbl), .o_fwd_valid(o_fwd_valid), .o_fwd(o_fwd),
    .o_pause_valid(o_pause_valid), .o_pause(o_pause));

  // ****************************************
  // compare and report
  // ****************************************
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // results are taken off the queues as they appear
  always @(negedge clk) begin
    if (o_wb_ack === 1'b1 && is_rd)
      cmp(o_wb_dat, exp_rd.size() ? exp_rd.pop_front() : 'x);
    if (o_fwd_valid === 1'b1)
      cmp(o_fwd, exp_fwd.size() ? exp_fwd.pop_front() : 'x);
    if (o_pause_valid === 1'b1)
      cmp(o_pause, exp_pause.size() ? exp_pause.pop_front() : 'x);
  end

  // ****************************************
  // bus and frame drivers
  // ****************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    is_rd = !w;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 100);
    if (n >= 100)
      cmp(1'b0, 1'b1);
    // released lines show the inverse so no stale value looks current
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= ~w;
    adr <= ~a;
    dat <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic ent(input logic [3:0] i, input logic [47:0] m,
                     input logic [2:0] p, input logic st);
    wb(1'b1, REG_ENT_MAC_LO, m[31:0]);
    wb(1'b1, REG_ENT_MAC_HI, {16'h0, m[47:32]});
    wb(1'b1, REG_ENT_CTRL, (32'h1 << ENT_VALID_BIT) |
      (32'(st) << ENT_STATIC_BIT) | (32'(p) << ENT_PORT_LSB) | 32'(i));
  endtask

  task automatic clear();
    f = '0;
    f.size_ok = 1'b1;
    f.sa = 48'({$urandom(), $urandom()});
    f.da = 48'({$urandom(), $urandom()});
    f.pause_quanta = 16'($urandom());
    t = '0;
    t.vlan_ports = 7'h7f;
    t.stp_ports = 7'h7f;
  endtask

  task automatic go(input port_set_t init, input logic loc);
    fwd_res_t e;
    port_set_t oh, m, s;
    logic dr;
    oh = 7'h01 << f.port;
    m = mask[f.port];
    dr = (f.err != 4'h0) | !f.size_ok | f.is_pause | f.is_mgmt | loc;
    s = t.igmp_hit ? t.igmp_ports : init;
    s = ((s & t.stp_ports) | t.mirror_ports) & m;
    s = t.acl_hit ? t.acl_ports : s;
    e.initial_dest_port_set = init;
    e.final_dest_port_set = dr ? 7'h00 : (s & m & ~oh);
    e.drop = dr;
    e.is_local = loc;
    exp_fwd.push_back(e);
    if (f.is_pause && f.err == 4'h0 && f.size_ok)
      exp_pause.push_back({f.port, f.pause_quanta});
    src.send(f, t);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    is_rd = 1'b0;
    void'($urandom(6));
    foreach (mask[p]) mask[p] = 7'h7f;
    mac_a = 48'h0a0b_0c0d_0e01;
    mac_b = 48'h0a0b_0c0d_0e02;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_AGE_PERIOD, 32'(AGE_DEFAULT_S));
    for (int p = 0; p < NUM_PORTS; p++)
      rd(8'(REG_EGR_MASK_BASE + 4 * p), 32'h7f);
    rd(REG_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    wb(1'b1, REG_AGE_PERIOD, 32'h0);
    rd(REG_AGE_PERIOD, 32'(AGE_MIN_S));
    wb(1'b1, REG_AGE_PERIOD, 32'h7ff);
    rd(REG_AGE_PERIOD, 32'(AGE_MAX_S));
    $display("test registers done");
    wb(1'b1, REG_CTRL, 32'h0);
    ent(4'h0, mac_a, 3'h2, 1'b0);
    ent(4'h1, mac_b, 3'h4, 1'b1);
    rd(REG_STATUS, 32'h2);
    clear(); f.da = mac_a;
    go(7'h04, 1'b0);
    clear(); f.da = mac_a; f.port = 3'h2;
    go(7'h04, 1'b1);
    clear(); f.sa = mac_a; f.port = 3'h5;
    go(7'h7f, 1'b0);
    clear(); f.da = mac_a;
    go(7'h20, 1'b0);
    clear(); f.sa = mac_a; f.port = 3'h3; f.err = 4'($urandom_range(15, 1));
    go(7'h7f, 1'b0);
    clear(); f.sa = mac_a; f.port = 3'h3; f.size_ok = 1'b0;
    go(7'h7f, 1'b0);
    clear(); f.da = mac_a;
    go(7'h20, 1'b0);
    clear(); f.da = mac_a; t.static_hit = 1'b1; t.static_ports = 7'h08;
    go(7'h08, 1'b0);
    clear(); t.stp_ports = 7'h3c; t.mirror_ports = 7'h40;
    go(7'h7f, 1'b0);
    clear();
    t.igmp_hit = 1'b1;
    t.igmp_ports = 7'h0e;
    t.stp_ports = 7'h3f;
    go(7'h7f, 1'b0);
    clear(); t.acl_hit = 1'b1; t.acl_ports = 7'h03;
    go(7'h7f, 1'b0);
    clear(); f.is_pause = 1'b1; f.port = 3'h4;
    go(7'h7f, 1'b0);
    clear(); f.is_mgmt = 1'b1;
    go(7'h7f, 1'b0);
    $display("test forwarding done");
    wb(1'b1, 8'(REG_EGR_MASK_BASE + 4), 32'h05);
    mask[1] = 7'h05;
    rd(8'(REG_EGR_MASK_BASE + 4), 32'h05);
    clear(); f.port = 3'h1;
    go(7'h7f, 1'b0);
    clear(); f.port = 3'h1; t.acl_hit = 1'b1; t.acl_ports = 7'h7f;
    go(7'h7f, 1'b0);
    $display("test egress mask done");
    wb(1'b1, REG_AGE_PERIOD, 32'h2);
    repeat (60) @(posedge clk);
    rd(REG_STATUS, 32'h2);
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (10) begin
      clear(); f.sa = mac_a; f.port = 3'h5;
      go(7'h7f, 1'b0);
      repeat (4) @(posedge clk);
    end
    rd(REG_STATUS, 32'h2);
    repeat (60) @(posedge clk);
    rd(REG_STATUS, 32'h1);
    clear(); f.da = mac_a;
    go(7'h7f, 1'b0);
    $display("test aging done");
    repeat (5) @(posedge clk);
    cmp(exp_fwd.size() + exp_rd.size() + exp_pause.size(), 0);
    conclude();
  end
endmodule
